// >>> src/rpi_pkg.sv
// Constants, encodings and carrier types for the RGMII physical-side adapter.
// Assumes a tri-speed MAC beside it and pad DDR registers beyond it.
// Overview of operation
// - Transmit logic except the quadrature clock register runs on one reference clock; speed via enable only.
// - Transmit enable always high at 1G, 1-in-10 at 100M, 1-in-100 at 10M.
// - Every RGMII data and control output leaves a DDR output register.
// - Forwarded clock comes from a DDR register to match data delay.
// - At 1G forwarded clock lags data by 2 ns, mid data window.
// - Without delay element, clock register uses the 90-degree reference.
// - Unshifted reference clocks data, control and transmit datapath.
// - At 10/100 the clock register inputs toggle at the data rate.
// - PHY receive clock clocks all receive logic and receive stream.
// - A receive clock enable is derived and supplied to the MAC.
// - Transmit references may be shared; each receive clock is private.
package rpi_pkg;

  // Link speed selection
  typedef enum logic [1:0]
  {
    RPI_SPEED_10 = 2'h0,
    RPI_SPEED_100 = 2'h1,
    RPI_SPEED_1000 = 2'h2
  } rpi_speed_t;

  // Enable divider width and ratios
  localparam int RPI_CNT_W = 7;
  localparam logic [RPI_CNT_W-1:0] RPI_CNT_ZERO = 7'h00;
  localparam logic [RPI_CNT_W-1:0] RPI_CNT_ONE = 7'h01;
  localparam logic [RPI_CNT_W-1:0] RPI_DIV_100 = 7'h0A;
  localparam logic [RPI_CNT_W-1:0] RPI_DIV_10 = 7'h64;

  // Transmit buffer depth
  localparam int RPI_FIFO_DEPTH = 8;

  // Nibble and byte layout
  localparam int RPI_NIB_W = 4;
  localparam int RPI_BYTE_W = 8;

  // DDR pair for a 4-bit bus: rise edge then fall edge
  typedef struct packed
  {
    logic [RPI_NIB_W-1:0] rise;
    logic [RPI_NIB_W-1:0] fall;
  } rpi_ddr4_t;

  // DDR pair for a single pin
  typedef struct packed
  {
    logic rise;
    logic fall;
  } rpi_ddr1_t;

  // Transmit stream word
  typedef struct packed
  {
    logic err;
    logic [RPI_BYTE_W-1:0] data;
  } rpi_tx_word_t;

  // Receive stream word
  typedef struct packed
  {
    logic last;
    logic err;
    logic [RPI_BYTE_W-1:0] data;
  } rpi_rx_word_t;

  // Reset values and the fixed 1G forwarded clock pattern
  localparam rpi_ddr4_t RPI_DDR4_IDLE = '{rise: 4'h0, fall: 4'h0};
  localparam rpi_ddr1_t RPI_DDR1_IDLE = '{rise: 1'b0, fall: 1'b0};
  localparam rpi_ddr1_t RPI_TXC_GIG = '{rise: 1'b1, fall: 1'b0};
  localparam rpi_tx_word_t RPI_TX_IDLE = '{err: 1'b0, data: 8'h00};
  localparam rpi_rx_word_t RPI_RX_IDLE = '{last: 1'b0, err: 1'b0, data: 8'h00};

endpackage

// >>> src/rpi_rgmii_phy_if.sv
// RGMII physical-side adapter: transmit enable, DDR staging, clock
// forwarding, receive assembly and a small transmit buffer.
// Assumes pad DDR primitives outside that take the rise/fall pairs.
`timescale 1ns/1ps
`default_nettype none

module rpi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE_C = (AW+1)'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic next_in_ready;
  logic push;
  logic pop;

  always_comb
  begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (push && !pop)
    begin
      next_count = (AW+1)'(count + ONE_C);
    end
    else if (pop && !push)
    begin
      next_count = (AW+1)'(count - ONE_C);
    end
    // Registered ready so the stall reaches the source cleanly
    next_in_ready = next_count < DEPTH_C;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_in_ready <= 1'b0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      o_in_ready <= next_in_ready;
    end
  end

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  assign o_out_valid = count != '0;
  assign o_out_data = mem[rd_ptr];
endmodule

module rpi_rgmii_phy_if #(
  parameter bit USE_QUAD_CLK = 1'b1
) (
  // Transmit reference clocks and reset
  input wire logic i_mclk,
  input wire logic i_tx_reference_clock_quadrature,
  input wire logic i_reset_n,
  // Link speed, i_mclk domain
  input wire rpi_pkg::rpi_speed_t i_speed,
  // Transmit stream from user logic
  input wire logic i_tx_tvalid,
  input wire rpi_pkg::rpi_tx_word_t i_tx_tword,
  output logic o_tx_tready,
  output logic o_tx_enable,
  // RGMII transmit pairs towards pad DDR registers
  output var rpi_pkg::rpi_ddr4_t o_rgmii_txd,
  output var rpi_pkg::rpi_ddr1_t o_rgmii_tx_ctl,
  output var rpi_pkg::rpi_ddr1_t o_rgmii_txc,
  // RGMII receive pairs from pad DDR registers
  input wire logic i_rx_clk,
  input wire rpi_pkg::rpi_ddr4_t i_rgmii_rxd,
  input wire rpi_pkg::rpi_ddr1_t i_rgmii_rx_ctl,
  // Receive stream, i_rx_clk domain
  output logic o_rx_enable,
  output logic o_rx_tvalid,
  output var rpi_pkg::rpi_rx_word_t o_rx_tword
);
  import rpi_pkg::*;

  function automatic logic [RPI_CNT_W-1:0] div_of(input rpi_speed_t spd);
    div_of = (spd == RPI_SPEED_10) ? RPI_DIV_10 : RPI_DIV_100;
  endfunction

  // Level of the forwarded clock for one half-cycle slot
  function automatic logic txc_level(input logic [RPI_CNT_W-1:0] pos,
                                     input logic [RPI_CNT_W-1:0] div,
                                     input logic half_slot);
    logic [RPI_CNT_W-1:0] half;
    logic [RPI_CNT_W-1:0] p;
    logic [RPI_CNT_W:0] slot;
    half = div >> 1;
    p = (pos >= half) ? RPI_CNT_W'(pos - half) : pos;
    slot = {p, half_slot};
    txc_level = slot < {1'b0, half};
  endfunction

  // Transmit enable generator
  logic [RPI_CNT_W-1:0] cnt;
  logic [RPI_CNT_W-1:0] next_cnt;
  logic next_tx_ce;

  always_comb
  begin
    // One counter per instance, cleared at reset and held at zero at 1G
    if (i_speed == RPI_SPEED_1000 || cnt >= RPI_CNT_W'(div_of(i_speed) - 1'b1))
    begin
      next_cnt = RPI_CNT_ZERO;
    end
    else
    begin
      next_cnt = RPI_CNT_W'(cnt + RPI_CNT_ONE);
    end
    next_tx_ce = (i_speed == RPI_SPEED_1000) || (next_cnt == RPI_CNT_ZERO);
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt <= RPI_CNT_ZERO;
      o_tx_enable <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      o_tx_enable <= next_tx_ce;
    end
  end

  // Transmit buffer, drained only on enabled cycles
  logic fifo_valid;
  rpi_tx_word_t fifo_word;

  rpi_fifo #(
    .WIDTH($bits(rpi_tx_word_t)),
    .DEPTH(RPI_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_in_valid(i_tx_tvalid),
    .i_in_data(i_tx_tword),
    .o_in_ready(o_tx_tready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_word),
    .i_out_ready(o_tx_enable)
  );

  // Byte being sent, aligned with the delayed count
  logic cur_valid;
  rpi_tx_word_t cur;
  logic [RPI_CNT_W-1:0] cnt_d;
  logic next_cur_valid;
  rpi_tx_word_t next_cur;

  always_comb
  begin
    next_cur_valid = cur_valid;
    next_cur = cur;
    if (o_tx_enable)
    begin
      next_cur_valid = fifo_valid;
      if (fifo_valid)
      begin
        next_cur = fifo_word;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cur_valid <= 1'b0;
      cur <= RPI_TX_IDLE;
      cnt_d <= RPI_CNT_ZERO;
    end
    else
    begin
      cur_valid <= next_cur_valid;
      cur <= next_cur;
      cnt_d <= cnt;
    end
  end

  // DDR staging of data, control and forwarded clock pattern
  rpi_ddr4_t txd_s1;
  rpi_ddr1_t ctl_s1;
  rpi_ddr1_t txc_s1;
  rpi_ddr4_t next_txd_s1;
  rpi_ddr1_t next_ctl_s1;
  rpi_ddr1_t next_txc_s1;
  logic [RPI_NIB_W-1:0] nib;
  logic [RPI_CNT_W-1:0] div;

  always_comb
  begin
    div = div_of(i_speed);
    nib = (cnt_d < (div >> 1)) ? cur.data[RPI_NIB_W-1:0]
                               : cur.data[RPI_BYTE_W-1:RPI_NIB_W];
    next_ctl_s1.rise = cur_valid;
    next_ctl_s1.fall = cur_valid ^ cur.err;
    if (i_speed == RPI_SPEED_1000)
    begin
      next_txd_s1.rise = cur.data[RPI_NIB_W-1:0];
      next_txd_s1.fall = cur.data[RPI_BYTE_W-1:RPI_NIB_W];
      next_txc_s1 = RPI_TXC_GIG;
    end
    else
    begin
      // Same nibble on both edges at the slow rates
      next_txd_s1.rise = nib;
      next_txd_s1.fall = nib;
      next_txc_s1.rise = txc_level(cnt_d, div, 1'b0);
      next_txc_s1.fall = txc_level(cnt_d, div, 1'b1);
    end
  end

  rpi_ddr4_t txd_s2;
  rpi_ddr1_t ctl_s2;
  rpi_ddr1_t txc_s2;

  // Second stage keeps data in step with the crossed clock pattern
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      txd_s1 <= RPI_DDR4_IDLE;
      ctl_s1 <= RPI_DDR1_IDLE;
      txc_s1 <= RPI_DDR1_IDLE;
      txd_s2 <= RPI_DDR4_IDLE;
      ctl_s2 <= RPI_DDR1_IDLE;
      txc_s2 <= RPI_DDR1_IDLE;
      o_rgmii_txd <= RPI_DDR4_IDLE;
      o_rgmii_tx_ctl <= RPI_DDR1_IDLE;
    end
    else
    begin
      txd_s1 <= next_txd_s1;
      ctl_s1 <= next_ctl_s1;
      txc_s1 <= next_txc_s1;
      txd_s2 <= txd_s1;
      ctl_s2 <= ctl_s1;
      txc_s2 <= txc_s1;
      o_rgmii_txd <= txd_s2;
      o_rgmii_tx_ctl <= ctl_s2;
    end
  end

  generate
    if (USE_QUAD_CLK)
    begin : g_quad
      rpi_ddr1_t txc_meta;
      // Pattern changes slowly, so a two-stage crossing is safe
      always_ff @(posedge i_tx_reference_clock_quadrature or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          txc_meta <= RPI_DDR1_IDLE;
          o_rgmii_txc <= RPI_DDR1_IDLE;
        end
        else
        begin
          txc_meta <= txc_s1;
          o_rgmii_txc <= txc_meta;
        end
      end
    end
    else
    begin : g_delay
      // External output delay element supplies the 2 ns lag
      always_ff @(posedge i_mclk or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          o_rgmii_txc <= RPI_DDR1_IDLE;
        end
        else
        begin
          o_rgmii_txc <= txc_s2;
        end
      end
    end
  endgenerate

  // Receive side: every flop here runs on this PHY's own clock
  rpi_ddr4_t rxd_meta;
  rpi_ddr4_t rxd_s;
  rpi_ddr1_t ctl_meta;
  rpi_ddr1_t ctl_s;
  rpi_speed_t spd_meta;
  rpi_speed_t spd_s;

  always_ff @(posedge i_rx_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rxd_meta <= RPI_DDR4_IDLE;
      rxd_s <= RPI_DDR4_IDLE;
      ctl_meta <= RPI_DDR1_IDLE;
      ctl_s <= RPI_DDR1_IDLE;
      spd_meta <= RPI_SPEED_10;
      spd_s <= RPI_SPEED_10;
    end
    else
    begin
      rxd_meta <= i_rgmii_rxd;
      rxd_s <= rxd_meta;
      ctl_meta <= i_rgmii_rx_ctl;
      ctl_s <= ctl_meta;
      spd_meta <= i_speed;
      spd_s <= spd_meta;
    end
  end

  // Receive assembly
  logic phase;
  logic [RPI_NIB_W-1:0] low;
  logic dv_d;
  logic err_acc;
  logic held_valid;
  logic [RPI_BYTE_W-1:0] held;
  logic next_phase;
  logic [RPI_NIB_W-1:0] next_low;
  logic next_err_acc;
  logic next_held_valid;
  logic [RPI_BYTE_W-1:0] next_held;
  logic next_rx_ce;
  logic next_rx_tvalid;
  rpi_rx_word_t next_rx_tword;
  logic gig;
  logic dv;
  logic byte_ok;
  logic frame_end;
  logic [RPI_BYTE_W-1:0] new_byte;

  always_comb
  begin
    gig = spd_s == RPI_SPEED_1000;
    dv = ctl_s.rise;
    frame_end = dv_d && !dv;
    byte_ok = dv && (gig || phase);
    new_byte = gig ? {rxd_s.fall, rxd_s.rise} : {rxd_s.rise, low};
    next_phase = (!gig && dv) ? !phase : 1'b0;
    next_low = phase ? low : rxd_s.rise;
    next_rx_ce = gig || byte_ok;
    // Falling-edge level is valid xor error, so a mismatch marks an error
    next_err_acc = frame_end ? 1'b0 : (err_acc || (dv && ctl_s.fall != dv));
    next_held_valid = held_valid;
    next_held = held;
    next_rx_tvalid = 1'b0;
    next_rx_tword = o_rx_tword;
    // One byte held back so the last one can be flagged
    if (byte_ok)
    begin
      next_rx_tvalid = held_valid;
      next_rx_tword = '{last: 1'b0, err: 1'b0, data: held};
      next_held = new_byte;
      next_held_valid = 1'b1;
    end
    else if (frame_end && held_valid)
    begin
      next_rx_tvalid = 1'b1;
      next_rx_tword = '{last: 1'b1, err: err_acc, data: held};
      next_held_valid = 1'b0;
    end
  end

  always_ff @(posedge i_rx_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      phase <= 1'b0;
      low <= '0;
      dv_d <= 1'b0;
      err_acc <= 1'b0;
      held_valid <= 1'b0;
      held <= '0;
      o_rx_enable <= 1'b0;
      o_rx_tvalid <= 1'b0;
      o_rx_tword <= RPI_RX_IDLE;
    end
    else
    begin
      phase <= next_phase;
      low <= next_low;
      dv_d <= dv;
      err_acc <= next_err_acc;
      held_valid <= next_held_valid;
      held <= next_held;
      o_rx_enable <= next_rx_ce;
      o_rx_tvalid <= next_rx_tvalid;
      o_rx_tword <= next_rx_tword;
    end
  end

  // Checks on the transmit enable and DDR staging
  AST_TX_CE_GIG: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_speed == RPI_SPEED_1000 |=> o_tx_enable)
    else $error("tx enable low at 1G");

  AST_TX_CE_100: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_speed == RPI_SPEED_100 && cnt == 7'h09 |=> o_tx_enable && cnt == 7'h00)
    else $error("tx enable missed tenth cycle");

  AST_TX_CE_10: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_speed == RPI_SPEED_10 && cnt == 7'h63 |=> o_tx_enable)
    else $error("tx enable missed hundredth cycle");

  AST_TX_CE_SPARSE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_speed != RPI_SPEED_1000 && cnt < 7'h09 ##1 i_speed != RPI_SPEED_1000
    |-> !o_tx_enable)
    else $error("tx enable high mid period");

  AST_TX_DDR_GIG: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_speed == RPI_SPEED_1000 |=>
    txd_s1.rise == $past(cur.data[3:0]) && txd_s1.fall == $past(cur.data[7:4])
    ##2 o_rgmii_txd == $past(txd_s1, 2))
    else $error("1G nibble order wrong");

  AST_TXC_GIG: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_speed == RPI_SPEED_1000 |=> txc_s1.rise && !txc_s1.fall)
    else $error("1G forwarded clock pattern wrong");

  AST_TXC_100: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_speed == RPI_SPEED_100 && cnt_d == 7'h02 |=> txc_s1.rise && !txc_s1.fall)
    else $error("25 MHz clock mid edge wrong");

  AST_TXC_10: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_speed == RPI_SPEED_10 && cnt_d == 7'h19 |=> !txc_s1.rise && !txc_s1.fall)
    else $error("2.5 MHz clock low half wrong");

  // Checks on the receive side
  AST_RX_CE_GIG: assert property (@(posedge i_rx_clk) disable iff (!i_reset_n)
    spd_s == RPI_SPEED_1000 |=> o_rx_enable)
    else $error("rx enable low at 1G");

  AST_RX_LAST: assert property (@(posedge i_rx_clk) disable iff (!i_reset_n)
    frame_end && held_valid && !byte_ok |=> o_rx_tvalid && o_rx_tword.last)
    else $error("frame end not flagged");
endmodule

`default_nettype wire

// >>> testbench/rgmii_phy_interface_logic_test.sv
// Self-checking bench for the RGMII adapter beside a PHY model.
// Assumes the adapter's own assertions guard its cycle rules.
`timescale 1ns/1ps
`default_nettype none
module rgmii_phy_interface_logic_test;
  import rpi_pkg::*;

  logic mclk, quad_clk, reset_n, tx_tvalid, tx_tready, tx_enable;
  logic rx_clk, rx_enable, rx_tvalid;
  logic [3:0] lo_nib;
  rpi_speed_t speed;
  rpi_tx_word_t tx_tword;
  rpi_ddr4_t txd, rxd;
  rpi_ddr1_t tx_ctl, txc, rx_ctl;
  rpi_rx_word_t rx_tword;
  int n_mismatch = 0;
  int total_checks = 0;
  int fcnt = 0;
  int pair_bad = 0;
  int rx_en_cnt = 0;
  int per = 10;
  logic [8:0] capq[$];
  rpi_rx_word_t rxq[$];

  rpi_rgmii_phy_if #(.USE_QUAD_CLK(1'b1)) DUT (
    .i_mclk(mclk), .i_tx_reference_clock_quadrature(quad_clk),
    .i_reset_n(reset_n), .i_speed(speed), .i_tx_tvalid(tx_tvalid),
    .i_tx_tword(tx_tword), .o_tx_tready(tx_tready),
    .o_tx_enable(tx_enable), .o_rgmii_txd(txd), .o_rgmii_tx_ctl(tx_ctl),
    .o_rgmii_txc(txc), .i_rx_clk(rx_clk), .i_rgmii_rxd(rxd),
    .i_rgmii_rx_ctl(rx_ctl), .o_rx_enable(rx_enable),
    .o_rx_tvalid(rx_tvalid), .o_rx_tword(rx_tword));
  rpi_phy_model phy (.o_rx_clk(rx_clk), .o_rxd(rxd), .o_rx_ctl(rx_ctl));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    quad_clk = 1'b0;
    #1.25;
    forever #2.5 quad_clk = ~quad_clk;
  end

  // Pins are read before this edge's own updates land
  always @(posedge mclk)
  begin
    if (tx_ctl.rise === 1'b1)
    begin
      if (speed == RPI_SPEED_1000)
        capq.push_back({tx_ctl.fall, txd.fall, txd.rise});
      else
      begin
        per = (speed == RPI_SPEED_10) ? 100 : 10;
        if (fcnt % per == per / 4) lo_nib = txd.rise;
        if (fcnt % per == per * 3 / 4)
          capq.push_back({tx_ctl.fall, txd.rise, lo_nib});
        if (txd.rise !== txd.fall) pair_bad++;
      end
      fcnt++;
    end
    else
      fcnt = 0;
  end

  always @(posedge rx_clk)
  begin
    if (rx_tvalid === 1'b1) rxq.push_back(rx_tword);
    if (rx_enable === 1'b1) rx_en_cnt++;
  end

  task automatic check_val(input logic [15:0] got, exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, exp, input string what);
    total_checks++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("Error at %0t: %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  function automatic logic [7:0] wd(input int i);
    return 8'(8'h31 + i * 37);
  endfunction

  // Offer one word and hold it until the edge that takes it
  task automatic push(input rpi_tx_word_t w);
    int k;
    k = 0;
    tx_tvalid = 1'b1;
    tx_tword = w;
    // Ready is read settled, before the edge that takes the word
    while (tx_tready !== 1'b1 && k < 500)
    begin
      k++;
      tick(1);
    end
    tick(1);
    if (k == 500)
    begin
      n_mismatch++;
      $display("Error at %0t: push never accepted", $time);
    end
  endtask

  task automatic test_enable();
    int cnt, rises, highs, prev, gap_bad, div;
    logic last_rise;
    rpi_speed_t sp[3] = '{RPI_SPEED_1000, RPI_SPEED_100, RPI_SPEED_10};
    foreach (sp[j])
    begin
      speed = sp[j];
      div = (j == 0) ? 1 : (j == 1) ? 10 : 100;
      tick(300);
      cnt = 0;
      rises = 0;
      highs = 0;
      gap_bad = 0;
      prev = -1;
      last_rise = txc.rise;
      for (int i = 0; i < 1000; i++)
      begin
        if (tx_enable === 1'b1)
        begin
          if (prev >= 0 && i - prev != div) gap_bad++;
          prev = i;
          cnt++;
        end
        highs += int'(txc.rise) + int'(txc.fall);
        if (txc.rise === 1'b1 && last_rise === 1'b0) rises++;
        last_rise = txc.rise;
        tick(1);
      end
      check_cnt(cnt, 1000 / div, "enable count");
      check_cnt(gap_bad, 0, "enable spacing");
      check_cnt(highs, 1000, "clock duty");
      check_cnt(rises, (div == 1) ? 0 : 2000 / div, "clock rate");
    end
  endtask

  task automatic test_tx_gig();
    speed = RPI_SPEED_1000;
    tick(20);
    capq.delete();
    check_val({14'h0, txc}, {14'h0, RPI_TXC_GIG}, "gig clock");
    for (int i = 0; i < 6; i++) push('{err: (i == 3), data: wd(i)});
    tx_tvalid = 1'b0;
    tick(20);
    check_cnt(capq.size(), 6, "tx bytes");
    for (int i = 0; i < 6; i++)
      check_val({7'h0, capq[i]}, {7'h0, i != 3, wd(i)}, "tx byte");
  endtask

  // Fill until refused, then drain at one byte per enable
  task automatic test_tx_slow(input rpi_speed_t sp);
    int zeros;
    speed = sp;
    tick(20);
    capq.delete();
    pair_bad = 0;
    zeros = 0;
    for (int i = 0; i < 9; i++) push('{err: 1'b0, data: wd(i)});
    tx_tvalid = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      tick(1);
      if (tx_tready === 1'b0) zeros++;
    end
    check_cnt(int'(zeros > 0), 1, "buffer refusal");
    push('{err: 1'b0, data: wd(9)});
    tx_tvalid = 1'b0;
    tick(1200);
    check_cnt(capq.size(), 10, "slow bytes");
    for (int i = 0; i < 10; i++)
      check_val({7'h0, capq[i]}, {7'h0, 1'b1, wd(i)}, "slow byte");
    check_cnt(pair_bad, 0, "nibble pairs");
    check_val({15'h0, tx_tready}, 16'h0001, "drained ready");
  endtask

  task automatic test_rx(input rpi_speed_t sp);
    logic [7:0] b[$];
    b = '{8'h12, 8'h34, 8'hA5, 8'h0F, 8'hC3};
    tick(1);
    speed = sp;
    phy.idle(4);
    rxq.delete();
    rx_en_cnt = 0;
    phy.send_frame(b, sp == RPI_SPEED_1000, (sp == RPI_SPEED_1000) ? 2 : -1);
    check_cnt(rx_en_cnt, (sp == RPI_SPEED_1000) ? 14 : 5, "rx enable");
    check_cnt(rxq.size(), 5, "rx words");
    foreach (b[i])
      check_val({6'h0, rxq[i]},
                {6'h0, i == 4, (i == 4) && (sp == RPI_SPEED_1000), b[i]},
                "rx word");
  endtask

  initial
  begin
    reset_n = 1'b0;
    speed = RPI_SPEED_100;
    tx_tvalid = 1'b0;
    tx_tword = RPI_TX_IDLE;
    fork
      repeat (20) @(posedge mclk);
      phy.idle(3);
    join
    tick(1);
    check_val({15'h0, tx_tready}, 16'h0, "ready in reset");
    check_val({4'h0, txd, tx_ctl, txc}, 16'h0, "pins in reset");
    reset_n = 1'b1;
    tick(2);
    check_val({15'h0, tx_tready}, 16'h0001, "ready after reset");
    test_enable();
    test_tx_gig();
    test_tx_slow(RPI_SPEED_10);
    test_tx_slow(RPI_SPEED_100);
    test_rx(RPI_SPEED_100);
    test_rx(RPI_SPEED_1000);
    finish_test();
  end

  // Whole run is near 40 us; this cuts a hang well beyond it
  initial
  begin
    #200000;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire

// >>> testbench/rpi_phy_model.sv
// PHY-side model: makes its own receive clock and DDR receive pairs.
// Assumes the bench calls its tasks; the clock stands still between calls.
`timescale 1ns/1ps
`default_nettype none
module rpi_phy_model (
  // Receive clock and pairs towards the adapter
  output var logic o_rx_clk,
  output var rpi_pkg::rpi_ddr4_t o_rxd,
  output var rpi_pkg::rpi_ddr1_t o_rx_ctl
);
  import rpi_pkg::*;

  initial
  begin
    o_rx_clk = 1'b0;
    o_rxd = '{rise: 4'hA, fall: 4'h5};
    o_rx_ctl = RPI_DDR1_IDLE;
  end

  // One period of this PHY's private clock; pairs move while it is low
  task automatic pulse();
    #62.5;
    o_rx_clk = 1'b1;
    #62.5;
    o_rx_clk = 1'b0;
  endtask

  // No frame: data lines wander so stale bits never pass for data
  task automatic idle(input int n);
    repeat (n)
    begin
      o_rx_ctl = RPI_DDR1_IDLE;
      o_rxd = ~o_rxd;
      pulse();
    end
  endtask

  // Byte number bad carries an error; falling level is valid xor error
  task automatic send_frame(input logic [7:0] b[$], input bit gig,
                            input int bad);
    #3.7;
    idle(3);
    foreach (b[i])
    begin
      o_rx_ctl = '{rise: 1'b1, fall: (i != bad)};
      if (gig)
      begin
        o_rxd = '{rise: b[i][3:0], fall: b[i][7:4]};
        pulse();
      end
      else
      begin
        o_rxd = '{rise: b[i][3:0], fall: b[i][3:0]};
        pulse();
        o_rxd = '{rise: b[i][7:4], fall: b[i][7:4]};
        pulse();
      end
    end
    idle(6);
  endtask
endmodule
`default_nettype wire
